// *** jpts_pkg.sv ***
// constants, types and the register map of the jog and point table sequencer
// assumes an axi4-lite master and an update-cycle clock of 50 MHz
//
// How it works
// - jog mode: 0 free-running, 1 step
// - direction: 0 positive, 1 negative
// - profile: 0 trapezoidal, 1 s-curve
// - free-run accelerates to peak, holds until stop
// - free-run moves at once on start
// - start released: decelerate to standstill
// - start again while decelerating: re-accelerate
// - step target is position plus offset, minus offset when direction is negative
// - after delay with start held, step again
// - step travel whole offset multiples unless a stop or jog enable clear cuts a step short
// - delay 0 to 65535 ms, whole cycles
// - jog only while jog enable set
// - points chain, next loaded after command-stop or in-position plus dwell
// - storage for up to 32K points
// - two 16-entry halves run and refill alternately
// - next point update within 1 ms
// - record: position, rates, speeds, dwell, option, angle
// - option bit 0: relative when 1
// - option bit 2: arc when 1
// - option bit 4: in-position, else command-stop
// - option bit 5: last point, stop after
package jpts_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned DELAY_MAX_MS  = 65535;
  localparam int unsigned UPDATE_MAX_MS = 1;
  localparam int unsigned UPDATE_MAX_CYC = UPDATE_MAX_MS * CYC_PER_MS;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] JOGCFG_OFS = 8'h04;
  localparam logic [7:0] SPEED_OFS  = 8'h08;
  localparam logic [7:0] ACC_OFS    = 8'h0C;
  localparam logic [7:0] DEC_OFS    = 8'h10;
  localparam logic [7:0] OFFS_OFS   = 8'h14;
  localparam logic [7:0] DELAY_OFS  = 8'h18;
  localparam logic [7:0] STAT_OFS   = 8'h1C;
  localparam logic [7:0] POS_OFS    = 8'h20;
  localparam logic [7:0] VEL_OFS    = 8'h24;
  localparam logic [7:0] PTIDX_OFS  = 8'h28;
  localparam logic [7:0] PTDAT_OFS  = 8'h2C;
  localparam logic [7:0] PTFLD_OFS  = 8'h30;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_JOGEN  = 0;
  localparam int CTRL_START  = 1;
  localparam int CTRL_PTRUN  = 2;
  localparam int CTRL_STOP   = 3;
  localparam int JC_MODE     = 0;
  localparam int JC_DIR      = 1;
  localparam int JC_PAT      = 2;
  localparam int OPT_REL     = 0;
  localparam int OPT_ARC     = 2;
  localparam int OPT_INP     = 4;
  localparam int OPT_LAST    = 5;

  // point record fields, selected by the field register
  localparam int NFIELD      = 11;
  localparam logic [3:0] F_POS   = 4'h0;
  localparam logic [3:0] F_ACCT  = 4'h1;
  localparam logic [3:0] F_DECT  = 4'h2;
  localparam logic [3:0] F_ACC   = 4'h3;
  localparam logic [3:0] F_DEC   = 4'h4;
  localparam logic [3:0] F_VINIT = 4'h5;
  localparam logic [3:0] F_VMAX  = 4'h6;
  localparam logic [3:0] F_VEND  = 4'h7;
  localparam logic [3:0] F_ANGLE = 4'h8;
  localparam logic [3:0] F_DWELL = 4'h9;
  localparam logic [3:0] F_OPT   = 4'hA;
  localparam logic signed [31:0] ANGLE_MAX = 32'sd360;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {JPTS_OKAY = 2'b00, JPTS_SLVERR = 2'b10} jpts_resp_e;
  typedef enum {JS_IDLE, JS_ACCEL, JS_RUN, JS_DECEL, JS_STEP, JS_WAIT} jpts_jog_e;
  typedef enum {PS_IDLE, PS_MOVE, PS_FINISH, PS_DWELL} jpts_pt_e;
endpackage

// *** jpts_seq.sv ***
// jog and point table sequencer: one axis, axi4-lite registers
// assumes in-position and command-stop feedback are synchronous to aclk
`timescale 1ns/100ps
`default_nettype none
module jpts_seq
#(
  parameter int DEPTH    = 32768,
  parameter int HALF     = 16,
  parameter int CYC_MS   = jpts_pkg::CYC_PER_MS
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // servo feedback
  input  wire logic        in_position_feedback,
  input  wire logic        command_stop_indication,
  // motion command out
  output var  logic signed [31:0] cmd_target,
  output var  logic signed [31:0] cmd_velocity,
  output var  logic        cmd_arc,
  output var  logic        cmd_scurve,
  output var  logic        cmd_load,
  output var  logic        refill_req
);
  import jpts_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int HW = $clog2(HALF);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic              jog_en_reg, start_input_reg, pt_run_reg;
  logic              jog_mode_select_reg, jog_direction_reg, profile_pattern_reg;
  logic [31:0]       jog_peak_speed_reg, acc_reg, dec_reg, step_offset_reg;
  logic [15:0]       step_repeat_delay_reg;
  logic [AW-1:0]     wr_idx_reg;
  logic [3:0]        fld_reg;
  logic signed [31:0] pos_reg, vel_reg;
  logic signed [31:0] mem [DEPTH][NFIELD];

  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg, w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        stop_pulse;
  logic        seg_done, pt_last_done;

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= JPTS_OKAY;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= RST_ZERO;
      w_strb_reg    <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > PTFLD_OFS || aw_addr_reg[1:0] != 2'b00 ||
                         aw_addr_reg == STAT_OFS) ? JPTS_SLVERR : JPTS_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // only full-word writes are meaningful for these fields
  logic wr_ok;
  assign wr_ok = wr_fire && (w_strb_reg == 4'hF);
  assign stop_pulse = wr_ok && aw_addr_reg == CTRL_OFS && w_data_reg[CTRL_STOP];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      jog_en_reg            <= 1'b0;
      start_input_reg       <= 1'b0;
      pt_run_reg            <= 1'b0;
      jog_mode_select_reg   <= 1'b0;
      jog_direction_reg     <= 1'b0;
      profile_pattern_reg   <= 1'b0;
      jog_peak_speed_reg    <= RST_ZERO;
      acc_reg               <= RST_ZERO;
      dec_reg               <= RST_ZERO;
      step_offset_reg       <= RST_ZERO;
      step_repeat_delay_reg <= 16'h0000;
      wr_idx_reg            <= '0;
      fld_reg               <= 4'h0;
    end
    else
    begin
      if (pt_last_done)
        pt_run_reg <= 1'b0;
      if (wr_ok)
      begin
        case (aw_addr_reg)
          CTRL_OFS:
          begin
            jog_en_reg      <= w_data_reg[CTRL_JOGEN];
            start_input_reg <= w_data_reg[CTRL_START];
            pt_run_reg      <= w_data_reg[CTRL_PTRUN] && !w_data_reg[CTRL_STOP];
          end
          JOGCFG_OFS:
          begin
            jog_mode_select_reg <= w_data_reg[JC_MODE];
            jog_direction_reg   <= w_data_reg[JC_DIR];
            profile_pattern_reg <= w_data_reg[JC_PAT];
          end
          SPEED_OFS: jog_peak_speed_reg    <= w_data_reg;
          ACC_OFS:   acc_reg               <= w_data_reg;
          DEC_OFS:   dec_reg               <= w_data_reg;
          OFFS_OFS:  step_offset_reg       <= w_data_reg;
          DELAY_OFS: step_repeat_delay_reg <= w_data_reg[15:0];
          PTIDX_OFS: wr_idx_reg            <= w_data_reg[AW-1:0];
          PTFLD_OFS: fld_reg               <= w_data_reg[3:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (wr_ok && aw_addr_reg == PTDAT_OFS && fld_reg < 4'(NFIELD))
    begin
      if (fld_reg == F_ANGLE && ($signed(w_data_reg) > ANGLE_MAX ||
          $signed(w_data_reg) < -ANGLE_MAX))
        mem[wr_idx_reg][fld_reg] <= ($signed(w_data_reg) > 0) ? ANGLE_MAX : -ANGLE_MAX;
      else
        mem[wr_idx_reg][fld_reg] <= w_data_reg;
    end
  end

  // ---------------------------------------------------------------
  // jog sequencer
  // ---------------------------------------------------------------
  jpts_jog_e          jog_reg;
  logic [31:0]        delay_cnt_reg;
  logic signed [31:0] step_goal_reg;
  logic signed [31:0] vstep, vpeak, dir_sign;
  logic [31:0]        delay_cyc;

  assign dir_sign  = jog_direction_reg ? -32'sd1 : 32'sd1;
  assign vpeak     = $signed(jog_peak_speed_reg);
  assign vstep     = (acc_reg == RST_ZERO) ? 32'sd1 : $signed(acc_reg);
  assign delay_cyc = 32'(step_repeat_delay_reg) * 32'(CYC_MS);

  // ---------------------------------------------------------------
  // point table sequencer
  // ---------------------------------------------------------------
  jpts_pt_e      pt_reg;
  logic [AW-1:0] rd_idx_reg;
  logic [31:0]   dwell_cnt_reg;
  logic [31:0]   opt;

  assign opt      = mem[rd_idx_reg][F_OPT];
  assign seg_done = opt[OPT_INP] ? in_position_feedback : command_stop_indication;
  assign pt_last_done = pt_reg == PS_FINISH && seg_done && opt[OPT_LAST];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      jog_reg       <= JS_IDLE;
      vel_reg       <= RST_ZERO;
      pos_reg       <= RST_ZERO;
      step_goal_reg <= RST_ZERO;
      delay_cnt_reg <= RST_ZERO;
    end
    else if (!jog_en_reg || stop_pulse)
    begin
      jog_reg <= JS_IDLE;
      vel_reg <= RST_ZERO;
    end
    else
    begin
      pos_reg <= pos_reg + vel_reg;
      case (jog_reg)
        JS_IDLE:
          if (start_input_reg)
          begin
            if (jog_mode_select_reg)
            begin
              step_goal_reg <= pos_reg + dir_sign * $signed(step_offset_reg);
              jog_reg       <= JS_STEP;
            end
            else
              jog_reg <= JS_ACCEL;
          end
        JS_ACCEL, JS_RUN:
          if (!start_input_reg)
            jog_reg <= JS_DECEL;
          else
          begin
            // new peak speed is tracked on the fly
            if (vel_reg * dir_sign + vstep < vpeak)
              vel_reg <= vel_reg + dir_sign * vstep;
            else
            begin
              vel_reg <= dir_sign * vpeak;
              jog_reg <= JS_RUN;
            end
          end
        JS_DECEL:
          if (start_input_reg)
            jog_reg <= JS_ACCEL;
          else if (vel_reg * dir_sign <= $signed(dec_reg))
          begin
            vel_reg <= RST_ZERO;
            jog_reg <= JS_IDLE;
          end
          else
            vel_reg <= vel_reg - dir_sign * $signed(dec_reg);
        JS_STEP:
          // land exactly on the goal so travel stays a whole offset multiple
          if ((step_goal_reg - pos_reg) * dir_sign <= vpeak)
          begin
            pos_reg       <= step_goal_reg;
            vel_reg       <= RST_ZERO;
            delay_cnt_reg <= RST_ZERO;
            jog_reg       <= JS_WAIT;
          end
          else
            vel_reg <= dir_sign * vpeak;
        JS_WAIT:
          if (!start_input_reg)
            jog_reg <= JS_IDLE;
          else if (delay_cnt_reg >= delay_cyc)
          begin
            step_goal_reg <= pos_reg + dir_sign * $signed(step_offset_reg);
            jog_reg       <= JS_STEP;
          end
          else
            delay_cnt_reg <= delay_cnt_reg + 32'h0000_0001;
        default: jog_reg <= JS_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pt_reg        <= PS_IDLE;
      rd_idx_reg    <= '0;
      dwell_cnt_reg <= RST_ZERO;
      cmd_target    <= RST_ZERO;
      cmd_velocity  <= RST_ZERO;
      cmd_arc       <= 1'b0;
      cmd_scurve    <= 1'b0;
      cmd_load      <= 1'b0;
      refill_req    <= 1'b0;
    end
    else
    begin
      cmd_load <= 1'b0;
      if (jog_en_reg)
      begin
        cmd_target   <= pos_reg;
        cmd_velocity <= vel_reg;
        cmd_scurve   <= profile_pattern_reg;
        cmd_arc      <= 1'b0;
      end
      case (pt_reg)
        PS_IDLE:
          if (pt_run_reg && !jog_en_reg)
            pt_reg <= PS_MOVE;
        PS_MOVE:
        begin
          // three cycles from finish to next load with zero dwell, well inside the update budget
          cmd_target   <= opt[OPT_REL] ? cmd_target + mem[rd_idx_reg][F_POS]
                                       : mem[rd_idx_reg][F_POS];
          cmd_velocity <= mem[rd_idx_reg][F_VMAX];
          cmd_arc      <= opt[OPT_ARC];
          cmd_scurve   <= mem[rd_idx_reg][F_ACCT][0];
          cmd_load     <= 1'b1;
          pt_reg       <= PS_FINISH;
        end
        PS_FINISH:
          if (!pt_run_reg)
            pt_reg <= PS_IDLE;
          else if (seg_done)
          begin
            dwell_cnt_reg <= RST_ZERO;
            pt_reg        <= PS_DWELL;
          end
        PS_DWELL:
          if (dwell_cnt_reg >= 32'(mem[rd_idx_reg][F_DWELL][15:0]) * 32'(CYC_MS))
          begin
            // crossing a half boundary frees the half just finished
            refill_req <= (HW'(rd_idx_reg + 1'b1) == '0)
                          ? ~refill_req : refill_req;
            rd_idx_reg <= rd_idx_reg + 1'b1;
            pt_reg     <= (opt[OPT_LAST] || !pt_run_reg) ? PS_IDLE : PS_MOVE;
          end
          else
            dwell_cnt_reg <= dwell_cnt_reg + 32'h0000_0001;
        default: pt_reg <= PS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = RST_ZERO;
    case (s_axi_araddr)
      CTRL_OFS:   rd_val = {28'h0, 1'b0, pt_run_reg, start_input_reg, jog_en_reg};
      JOGCFG_OFS: rd_val = {29'h0, profile_pattern_reg, jog_direction_reg,
                            jog_mode_select_reg};
      SPEED_OFS:  rd_val = jog_peak_speed_reg;
      ACC_OFS:    rd_val = acc_reg;
      DEC_OFS:    rd_val = dec_reg;
      OFFS_OFS:   rd_val = step_offset_reg;
      DELAY_OFS:  rd_val = {16'h0, step_repeat_delay_reg};
      STAT_OFS:   rd_val = {26'h0, refill_req, rd_idx_reg[HW],
                            jog_reg != JS_IDLE, pt_reg != PS_IDLE, 2'b00};
      POS_OFS:    rd_val = pos_reg;
      VEL_OFS:    rd_val = vel_reg;
      PTIDX_OFS:  rd_val = 32'(rd_idx_reg);
      PTDAT_OFS:  rd_val = (fld_reg < 4'(NFIELD)) ? mem[wr_idx_reg][fld_reg] : RST_ZERO;
      PTFLD_OFS:  rd_val = {28'h0, fld_reg};
      default:    rd_val = RST_ZERO;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_ZERO;
      s_axi_rresp   <= JPTS_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= (s_axi_araddr > PTFLD_OFS || s_axi_araddr[1:0] != 2'b00)
                        ? JPTS_SLVERR : JPTS_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** jpts_seq_checker.sv ***
// checker on the top ports of the jog and point table sequencer
// assumes the bench offers write address and write data together
`timescale 1ns/100ps
`default_nettype none
module jpts_seq_checker
  import jpts_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // motion
  input wire logic signed [31:0] cmd_velocity,
  input wire logic        cmd_load
);
  logic        jog_en_reg;
  logic        dir_reg;
  logic [31:0] peak_reg;
  logic        wr_go;

  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // shadow of the jog settings, taken at the write handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      jog_en_reg <= 1'b0;
      dir_reg    <= 1'b0;
      peak_reg   <= 32'h0;
    end
    else if (wr_go)
    begin
      if (s_axi_awaddr == CTRL_OFS) jog_en_reg <= s_axi_wdata[CTRL_JOGEN];
      if (s_axi_awaddr == JOGCFG_OFS) dir_reg <= s_axi_wdata[JC_DIR];
      if (s_axi_awaddr == SPEED_OFS) peak_reg <= s_axi_wdata;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  jog_sign_a:
    assert property (jog_en_reg && cmd_velocity != 0 |-> cmd_velocity[31] == dir_reg)
    else $error("jog velocity sign differs from direction");
  peak_cap_a:
    assert property (jog_en_reg |->
      (cmd_velocity[31] ? -cmd_velocity : cmd_velocity) <= $signed(peak_reg))
    else $error("jog velocity above peak speed");
  load_pulse_a:
    assert property (cmd_load |=> !cmd_load)
    else $error("segment load longer than one cycle");
  write_answer_a:
    assert property (wr_go |=> ##1 s_axi_bvalid)
    else $error("write response late");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_once_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_once_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  err_zero_a:
    assert property (s_axi_rvalid && s_axi_rresp == JPTS_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returns data");

  cover property (cmd_load);
  cover property (jog_en_reg && cmd_velocity[31]);
  cover property (s_axi_rvalid && s_axi_rresp == JPTS_SLVERR);
endmodule

bind jpts_seq jpts_seq_checker i_jpts_seq_checker (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_velocity, .cmd_load);
`default_nettype wire

// *** jpts_servo_model.sv ***
// servo drive stand-in: command stop, later in position, after each segment load
// assumes cmd_load is a one-cycle pulse per segment
`timescale 1ns/100ps
`default_nettype none
module jpts_servo_model
#(
  parameter int STOP_CYC = 4,
  parameter int INP_CYC  = 12
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cmd_load,
  output var  logic command_stop_indication,
  output var  logic in_position_feedback
);
  int cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd_load)
      cnt <= 0;
    else if (cnt < INP_CYC)
      cnt <= cnt + 1;
  end

  // status drops while a segment is issued so a stale finish is never seen
  assign command_stop_indication = aresetn && !cmd_load && cnt >= STOP_CYC;
  assign in_position_feedback    = aresetn && !cmd_load && cnt >= INP_CYC;
endmodule
`default_nettype wire

// *** jpts_seq_test.sv ***
// self-checking bench for the jog and point table sequencer
// assumes the servo stand-in answers each segment load
`timescale 1ns/100ps
`default_nettype none
module jpts_seq_test;
  import jpts_pkg::*;
  localparam int CYC_MS   = 5;
  localparam int STOP_CYC = 4;
  localparam int INP_CYC  = 12;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, in_position_feedback, command_stop_indication;
  logic cmd_arc, cmd_scurve, cmd_load, refill_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [31:0] cmd_target, cmd_velocity;
  int errors, cmp_count, cyc, ntog;
  logic rf_q = 1'b0;
  logic [31:0] ltgt[$];
  logic larc[$];
  int lt[$];

  jpts_seq #(.DEPTH(64), .CYC_MS(CYC_MS)) i_jpts_seq (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_position_feedback,
    .command_stop_indication, .cmd_target, .cmd_velocity, .cmd_arc, .cmd_scurve, .cmd_load,
    .refill_req);
  jpts_servo_model #(.STOP_CYC(STOP_CYC), .INP_CYC(INP_CYC)) i_jpts_servo_model (.aclk,
    .aresetn, .cmd_load, .command_stop_indication, .in_position_feedback);

  always #10 aclk = ~aclk;

  // segment log; refill toggles are counted only out of reset
  always @(posedge aclk)
  begin
    cyc++;
    if (cmd_load === 1'b1)
    begin
      ltgt.push_back(cmd_target);
      larc.push_back(cmd_arc);
      lt.push_back(cyc);
    end
    if (aresetn && refill_req !== rf_q) ntog++;
    rf_q = refill_req;
  end

  // -------------
  // bus and checks
  // -------------
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e)
    begin
      errors++;
      $display("FAIL t=%0t act=%h exp=%h", $time, a, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bready and rready stay high, so only the valids move here
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 64);
    chk(s_axi_bvalid, 1'b1);
    chk(s_axi_bresp, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, JPTS_OKAY);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 64);
    d = s_axi_rdata;
    chk(s_axi_rvalid, 1'b1);
    chk(s_axi_rresp, r);
  endtask

  // -------------
  // scenarios
  // -------------
  task automatic t_regs();
    logic [31:0] d;
    wr(SPEED_OFS, 32'h0000_0123);
    axr(SPEED_OFS, d, JPTS_OKAY);
    chk(d, 32'h0000_0123);
    axr(8'h40, d, JPTS_SLVERR);
    chk(d, 32'h0);
    axw(STAT_OFS, 32'hFFFF_FFFF, JPTS_SLVERR);
    axw(8'h06, 32'h0, JPTS_SLVERR);
    wr(PTFLD_OFS, 32'h8);
    wr(PTDAT_OFS, 32'h0000_0190);
    axr(PTDAT_OFS, d, JPTS_OKAY);
    chk(d, 32'h0000_0168);
  endtask

  task automatic t_jog_off();
    logic [31:0] d;
    wr(JOGCFG_OFS, 32'h0);
    wr(SPEED_OFS, 32'hA);
    wr(ACC_OFS, 32'h2);
    wr(DEC_OFS, 32'h1);
    wr(CTRL_OFS, 32'h2);
    tick(20);
    chk(cmd_velocity, 32'h0);
    axr(VEL_OFS, d, JPTS_OKAY);
    chk(d, 32'h0);
    wr(CTRL_OFS, 32'h0);
  endtask

  task automatic t_free();
    wr(JOGCFG_OFS, 32'h6);
    wr(CTRL_OFS, 32'h3);
    // start lands one edge after the write, the ramp shows two edges later
    tick(3);
    chk({31'h0, cmd_velocity != 0}, 32'h1);
    chk(cmd_scurve, 32'h1);
    tick(12);
    chk(cmd_velocity, 32'hFFFF_FFF6);
    wr(SPEED_OFS, 32'h14);
    tick(12);
    chk(cmd_velocity, 32'hFFFF_FFEC);
    wr(CTRL_OFS, 32'h1);
    tick(3);
    chk({31'h0, cmd_velocity != 0 && cmd_velocity != 32'hFFFF_FFEC}, 32'h1);
    wr(CTRL_OFS, 32'h3);
    tick(15);
    chk(cmd_velocity, 32'hFFFF_FFEC);
    wr(CTRL_OFS, 32'h1);
    tick(30);
    chk(cmd_velocity, 32'h0);
    wr(CTRL_OFS, 32'h3);
    tick(15);
    wr(CTRL_OFS, 32'h9);
    tick(2);
    chk(cmd_velocity, 32'h0);
  endtask

  task automatic t_step();
    logic [31:0] p0, p1, p2;
    wr(JOGCFG_OFS, 32'h1);
    wr(SPEED_OFS, 32'h8);
    wr(OFFS_OFS, 32'h28);
    wr(DELAY_OFS, 32'h2);
    axr(POS_OFS, p0, JPTS_OKAY);
    wr(CTRL_OFS, 32'h3);
    tick(1);
    wr(CTRL_OFS, 32'h1);
    tick(30);
    // in jog the command output follows the position, so the goal shows on arrival
    chk(cmd_target, p0 + 32'h28);
    axr(POS_OFS, p1, JPTS_OKAY);
    chk(p1 - p0, 32'h28);
    wr(CTRL_OFS, 32'h3);
    tick(60);
    wr(CTRL_OFS, 32'h1);
    tick(40);
    axr(POS_OFS, p2, JPTS_OKAY);
    chk((p2 - p1) % 32'h28, 32'h0);
    chk({31'h0, (p2 - p1) > 32'h28}, 32'h1);
  endtask

  task automatic wpt(input int i, input logic [31:0] p, input logic [31:0] o);
    wr(PTIDX_OFS, 32'(i));
    for (int f = 0; f < NFIELD; f++)
    begin
      wr(PTFLD_OFS, 32'(f));
      wr(PTDAT_OFS, f == 0 ? p : f == 10 ? o : f == 6 ? 32'h10 : 32'h0);
    end
  endtask

  task automatic t_points();
    wr(CTRL_OFS, 32'h0);
    wpt(0, 32'h64, 32'h0);
    wpt(1, 32'h32, 32'h17);
    for (int i = 2; i < 16; i++)
      wpt(i, 32'(200 + i), 32'h4A);
    wpt(16, 32'h3E8, 32'hE8);
    ltgt.delete();
    larc.delete();
    lt.delete();
    ntog = 0;
    wr(CTRL_OFS, 32'h4);
    for (int k = 0; k < 3000 && ltgt.size() < 17; k++)
      @(posedge aclk);
    tick(100);
    chk(ltgt.size(), 32'd17);
    chk(ltgt[0], 32'h64);
    chk(ltgt[1], 32'h96);
    chk(ltgt[2], 32'hCA);
    chk(larc[0], 32'h0);
    chk(larc[1], 32'h1);
    chk(larc[2], 32'h0);
    chk(32'((lt[2] - lt[1]) - (lt[1] - lt[0])), 32'(INP_CYC - STOP_CYC));
    chk({31'h0, lt[1] - lt[0] <= STOP_CYC + CYC_MS + 2}, 32'h1);
    chk(32'(ntog), 32'h1);
  endtask

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    t_regs();
    t_jog_off();
    t_free();
    t_step();
    t_points();
    report_and_stop();
  end

  // the whole run needs a few thousand cycles
  initial
  begin
    tick(20000);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
